/* pkg/fss_pkg.sv */
// package for the switch, setting and status lamp logic of the fieldbus slave
package fss_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int INIT_MS = 100;
  localparam int INIT_CYC = INIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMR_W = 23;

  // ----------------------------------------------------------------------
  // register map (byte offsets) and field positions
  // ----------------------------------------------------------------------
  localparam int APB_AW = 12;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_SETTING = 12'h004;
  localparam logic [11:0] OFS_EVENT = 12'h008;
  localparam int STAT_OPER_BIT = 0;
  localparam int STAT_LINK_BIT = 1;
  localparam int STAT_HALT_BIT = 2;
  localparam int STAT_RANGE_BIT = 3;
  localparam int STAT_COMM_BIT = 4;
  localparam int STAT_MODE_BIT = 5;
  localparam int STAT_REF_LSB = 8;
  localparam int STAT_NOW_LSB = 16;
  localparam int SET_STN_LSB = 0;
  localparam int SET_RATE_LSB = 8;
  localparam int SET_MODE_BIT = 12;
  localparam int SET_OK_BIT = 13;
  localparam int EVT_CHG_BIT = 0;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // switch decoding
  // ----------------------------------------------------------------------
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] SEL_V2_FIRST = 4'h5;
  localparam logic [6:0] STATION_MIN = 7'h01;
  localparam logic [6:0] STATION_MAX_V1 = 7'h3f;
  localparam logic [6:0] STATION_MAX_V2 = 7'h3e;
  localparam int SNS_W = 5;

  typedef enum logic [2:0] {
    FSS_RATE_156K,
    FSS_RATE_625K,
    FSS_RATE_2M5,
    FSS_RATE_5M,
    FSS_RATE_10M
  } fss_rate_e;

  typedef enum logic {
    FSS_MODE_COMPACT,
    FSS_MODE_MONITOR
  } fss_mode_e;

  typedef enum logic [1:0] {
    FSS_PH_SAMPLE,
    FSS_PH_INIT,
    FSS_PH_OPER
  } fss_phase_e;

  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] ones;
    logic [3:0] rate;
  } fss_switch_s;

  typedef struct packed {
    logic [6:0] station;
    fss_rate_e rate;
    fss_mode_e mode;
    logic ok;
  } fss_setting_s;

  typedef struct packed {
    fss_phase_e phase;
    logic [TMR_W-1:0] init_cnt;
    logic [TMR_W-1:0] flash_cnt;
    logic blink;
    fss_switch_s sw;
    logic [SNS_W-1:0] sns_ref;
    logic chg;
    logic halt;
    logic [31:0] prdata;
    logic run_lamp;
    logic err_lamp;
    logic ss_grn;
    logic ss_red;
  } fss_state_s;

endpackage

/* rtl/fss_setting_decode.sv */
// decoder from latched switch positions to station, rate, mode and range check
`timescale 1ns/1ps
module fss_setting_decode
  import fss_pkg::*;
(
  input wire fss_switch_s sw_i,
  output fss_setting_s set_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic digit_ok(input logic [3:0] d);
    digit_ok = (d <= DIGIT_MAX);
  endfunction

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic [7:0] stn_wide;
  logic [3:0] rate_idx;
  logic [6:0] stn_max;

  // tens digit times ten plus ones digit; 8 bits so bad digits cannot wrap
  always_comb begin
    stn_wide = {4'h0, sw_i.tens} * 8'h0a + {4'h0, sw_i.ones};
    set_o.station = stn_wide[6:0];
    set_o.mode = (sw_i.rate >= SEL_V2_FIRST) ? FSS_MODE_MONITOR : FSS_MODE_COMPACT;
    rate_idx = (sw_i.rate >= SEL_V2_FIRST) ? sw_i.rate - SEL_V2_FIRST : sw_i.rate;
    set_o.rate = fss_rate_e'(rate_idx[2:0]);
    stn_max = (set_o.mode == FSS_MODE_MONITOR) ? STATION_MAX_V2 : STATION_MAX_V1;
    // a selector past 9 or a non-decimal digit counts as out of range
    set_o.ok = digit_ok(sw_i.tens) && digit_ok(sw_i.ones) && digit_ok(sw_i.rate)
      && (stn_wide[7] == 1'b0) && (stn_wide[6:0] >= STATION_MIN)
      && (stn_wide[6:0] <= stn_max);
  end

endmodule

/* rtl/fss_status_top.sv */
// switch latching, setting decode, change watch and status lamp control
`timescale 1ns/1ps
module fss_status_top
  import fss_pkg::*;
#(
  parameter int FLASH_CYC = FLASH_HALF_CYC,
  parameter int INIT_CYCLES = INIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [APB_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // front-panel switches
  input wire fss_switch_s sw_i,
  // link and sensor chain status
  input wire logic link_up_i,
  input wire logic comm_err_i,
  input wire logic mode_mismatch_i,
  input wire logic dup_station_i,
  input wire logic [SNS_W-1:0] sensor_cnt_i,
  // decoded settings and operation state
  output fss_setting_s setting_o,
  output logic halt_o,
  // lamps
  output logic run_lamp_o,
  output logic err_lamp_o,
  output logic ss_green_o,
  output logic ss_red_o
);

  // ----------------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------------
  fss_state_s s_q;
  fss_state_s s_d;
  fss_setting_s set;
  logic oper;
  logic hard_err;
  logic chg_set;
  logic chg_clr;
  logic wr_acc;
  logic setup;
  logic addr_ok;

  // decode works only on the latched copy, never the live switches
  fss_setting_decode u_decode (
    .sw_i(s_q.sw),
    .set_o(set)
  );

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  // zero wait states: every access completes in its first access cycle
  assign addr_ok = (paddr_i == OFS_STATUS) || (paddr_i == OFS_SETTING)
    || (paddr_i == OFS_EVENT);
  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pwrite_i && addr_ok;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  // ----------------------------------------------------------------------
  // condition terms
  // ----------------------------------------------------------------------
  assign oper = (s_q.phase == FSS_PH_OPER);
  // steady error sources; the flag of a moved switch only flashes
  assign hard_err = comm_err_i || !set.ok || mode_mismatch_i || s_q.halt;
  assign chg_set = oper && link_up_i && (sw_i != s_q.sw);
  assign chg_clr = wr_acc && (paddr_i == OFS_EVENT) && pwdata_i[EVT_CHG_BIT];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // flash divider free runs; one half period per blink phase
    if (s_q.flash_cnt == TMR_W'(FLASH_CYC - 1)) begin
      s_d.flash_cnt = '0;
      s_d.blink = !s_q.blink;
    end else begin
      s_d.flash_cnt = s_q.flash_cnt + 1'b1;
    end
    // power-up sequence: latch switches, settle, then operate
    case (s_q.phase)
      FSS_PH_SAMPLE: begin
        s_d.sw = sw_i;
        s_d.init_cnt = '0;
        s_d.phase = FSS_PH_INIT;
      end
      FSS_PH_INIT: begin
        // sensor count taken once the chain has had time to enumerate
        if (s_q.init_cnt == TMR_W'(INIT_CYCLES - 1)) begin
          s_d.sns_ref = sensor_cnt_i;
          s_d.phase = FSS_PH_OPER;
        end else begin
          s_d.init_cnt = s_q.init_cnt + 1'b1;
        end
      end
      FSS_PH_OPER: begin
        s_d.phase = FSS_PH_OPER;
      end
      default: begin
        s_d.phase = FSS_PH_SAMPLE;
      end
    endcase
    // switch-moved flag: a new change wins over a software clear
    s_d.chg = chg_set || (s_q.chg && !chg_clr);
    // duplicate station stops operation until the next power cycle
    if (oper && dup_station_i) begin
      s_d.halt = 1'b1;
    end
    // read data captured in the setup cycle, valid through the access cycle
    if (setup) begin
      case (paddr_i)
        OFS_STATUS: begin
          s_d.prdata = STATUS_RST;
          s_d.prdata[STAT_OPER_BIT] = oper;
          s_d.prdata[STAT_LINK_BIT] = link_up_i;
          s_d.prdata[STAT_HALT_BIT] = s_q.halt;
          s_d.prdata[STAT_RANGE_BIT] = !set.ok;
          s_d.prdata[STAT_COMM_BIT] = comm_err_i;
          s_d.prdata[STAT_MODE_BIT] = mode_mismatch_i;
          s_d.prdata[STAT_REF_LSB +: SNS_W] = s_q.sns_ref;
          s_d.prdata[STAT_NOW_LSB +: SNS_W] = sensor_cnt_i;
        end
        OFS_SETTING: begin
          s_d.prdata = '0;
          s_d.prdata[SET_STN_LSB +: 7] = set.station;
          s_d.prdata[SET_RATE_LSB +: 3] = set.rate;
          s_d.prdata[SET_MODE_BIT] = set.mode;
          s_d.prdata[SET_OK_BIT] = set.ok;
        end
        OFS_EVENT: begin
          s_d.prdata = '0;
          s_d.prdata[EVT_CHG_BIT] = s_q.chg;
        end
        default: begin
          s_d.prdata = '0;
        end
      endcase
    end
    // lamps; all dark until the power-up sequence ends
    s_d.run_lamp = oper && link_up_i && !s_q.halt;
    s_d.err_lamp = oper && (hard_err || (s_q.chg && s_q.blink));
    // no sensors attached keeps the lamp dark even if some were there before
    s_d.ss_grn = oper && (sensor_cnt_i != '0) && (sensor_cnt_i == s_q.sns_ref);
    s_d.ss_red = oper && (sensor_cnt_i != '0) && (sensor_cnt_i != s_q.sns_ref);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      s_q <= '{phase: FSS_PH_SAMPLE, sw: '0, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign prdata_o = s_q.prdata;
  assign setting_o = set;
  assign halt_o = s_q.halt;
  assign run_lamp_o = s_q.run_lamp;
  assign err_lamp_o = s_q.err_lamp;
  assign ss_green_o = s_q.ss_grn;
  assign ss_red_o = s_q.ss_red;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_mismatch_seen;
    oper && mode_mismatch_i;
  endsequence

  sequence s_dup_seen;
    oper && dup_station_i;
  endsequence

  property p_run_dark;
    !link_up_i |=> !run_lamp_o;
  endproperty
  a_run_dark: assert property (p_run_dark) else $error("run lamp lit without link");

  property p_run_lit;
    (oper && link_up_i && !halt_o) |=> run_lamp_o;
  endproperty
  a_run_lit: assert property (p_run_lit) else $error("run lamp dark during link");

  property p_chg_flash;
    (chg_set ##1 (s_q.blink && !chg_clr)) |=> err_lamp_o;
  endproperty
  a_chg_flash: assert property (p_chg_flash) else $error("error lamp not flashing on change");

  property p_err_steady;
    (oper && comm_err_i) |=> err_lamp_o;
  endproperty
  a_err_steady: assert property (p_err_steady) else $error("error lamp dark on comm error");

  property p_ss_init_dark;
    (s_q.phase != FSS_PH_OPER) |=> (!ss_green_o && !ss_red_o);
  endproperty
  a_ss_init_dark: assert property (p_ss_init_dark) else $error("sensor lamp lit in init");

  property p_ss_green;
    (oper && sensor_cnt_i != '0 && sensor_cnt_i == s_q.sns_ref) |=> (ss_green_o && !ss_red_o);
  endproperty
  a_ss_green: assert property (p_ss_green) else $error("sensor lamp not green");

  property p_ss_red;
    (oper && sensor_cnt_i != '0 && sensor_cnt_i != s_q.sns_ref) |=> (ss_red_o && !ss_green_o);
  endproperty
  a_ss_red: assert property (p_ss_red) else $error("sensor lamp not red");

  property p_mode;
    (s_q.sw.rate == 4'h4 |-> setting_o.mode == FSS_MODE_COMPACT)
      and (s_q.sw.rate == 4'h5 |-> setting_o.mode == FSS_MODE_MONITOR);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");

  property p_rate;
    (s_q.sw.rate == 4'h7 |-> setting_o.rate == FSS_RATE_2M5)
      and (s_q.sw.rate == 4'h0 |-> setting_o.rate == FSS_RATE_156K);
  endproperty
  a_rate: assert property (p_rate) else $error("rate decode wrong");

  property p_mismatch;
    s_mismatch_seen |=> err_lamp_o;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mode mismatch not shown");

  property p_latch_hold;
    oper |=> $stable(s_q.sw);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("switches relatched");

  property p_station;
    (s_q.sw.tens == 4'h4 && s_q.sw.ones == 4'h7) |-> setting_o.station == 7'h2f;
  endproperty
  a_station: assert property (p_station) else $error("station digits wrong");

  property p_range;
    (s_q.sw.tens == 4'h6 && s_q.sw.ones == 4'h3)
      |-> (setting_o.ok == (setting_o.mode == FSS_MODE_COMPACT));
  endproperty
  a_range: assert property (p_range) else $error("station range check wrong");

  property p_halt;
    // run lamp was computed before halt registered, so it goes dark one edge later
    s_dup_seen |=> halt_o ##1 (halt_o && !run_lamp_o && err_lamp_o);
  endproperty
  a_halt: assert property (p_halt) else $error("duplicate station did not halt");

  property p_err_dark;
    (!hard_err && !s_q.chg) |=> !err_lamp_o;
  endproperty
  a_err_dark: assert property (p_err_dark) else $error("error lamp lit without cause");

endmodule

/* bench/fss_master_model.sv */
// behavioural fieldbus master and sensor chain facing the status block
`timescale 1ns/1ps
module fss_master_model
  import fss_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic online_i,
  input wire logic fault_i,
  input wire logic other_mode_i,
  input wire logic clash_i,
  input wire logic [SNS_W-1:0] units_i,
  output logic link_up_o,
  output logic comm_err_o,
  output logic mode_mismatch_o,
  output logic dup_station_o,
  output logic [SNS_W-1:0] sensor_cnt_o
);
  // ----------------------------------------------------------------------
  // link state
  // ----------------------------------------------------------------------
  // master only reports faults while it talks; registered like a real link
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      link_up_o <= 1'b0;
      comm_err_o <= 1'b0;
      mode_mismatch_o <= 1'b0;
      dup_station_o <= 1'b0;
    end else begin
      link_up_o <= online_i;
      comm_err_o <= online_i & fault_i;
      mode_mismatch_o <= online_i & other_mode_i; // rate always matches
      dup_station_o <= online_i & clash_i; // unique station unless told
    end
  end

  // sensor chain count follows the bench, unit power is not tied to reset
  always_ff @(posedge ref_clk_i) begin
    sensor_cnt_o <= units_i;
  end
endmodule

/* bench/fss_status_top_test.sv */
// self-checking testbench of the switch and status lamp block
`timescale 1ns/1ps
module fss_status_top_test;
  import fss_pkg::*;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, link_up, comm_err, mm, dup;
  logic halt, run, err, ssg, ssr, online, fault, other_mode, clash, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [SNS_W-1:0] units, scnt;
  fss_switch_s sw;
  fss_setting_s setting;
  int errors, n_compared, n;
  // ----------------------------------------------------------------------
  // power-up settings: switches beside the decode they must give
  // ----------------------------------------------------------------------
  localparam logic [23:0] ROWS [0:14] = '{
    {12'h120, 7'd12, 3'd0, 2'b01}, {12'h121, 7'd12, 3'd1, 2'b01},
    {12'h122, 7'd12, 3'd2, 2'b01}, {12'h123, 7'd12, 3'd3, 2'b01},
    {12'h124, 7'd12, 3'd4, 2'b01}, {12'h125, 7'd12, 3'd0, 2'b11},
    {12'h126, 7'd12, 3'd1, 2'b11}, {12'h127, 7'd12, 3'd2, 2'b11},
    {12'h128, 7'd12, 3'd3, 2'b11}, {12'h129, 7'd12, 3'd4, 2'b11},
    {12'h630, 7'd63, 3'd0, 2'b01}, {12'h640, 7'd64, 3'd0, 2'b00},
    {12'h625, 7'd62, 3'd0, 2'b11}, {12'h635, 7'd63, 3'd0, 2'b10},
    {12'h000, 7'd0, 3'd0, 2'b00}};

  fss_status_top #(.FLASH_CYC(4), .INIT_CYCLES(8)) fss_status_top_i (
    .ref_clk_i(ref_clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sw_i(sw), .link_up_i(link_up),
    .comm_err_i(comm_err), .mode_mismatch_i(mm), .dup_station_i(dup),
    .sensor_cnt_i(scnt), .setting_o(setting), .halt_o(halt), .run_lamp_o(run),
    .err_lamp_o(err), .ss_green_o(ssg), .ss_red_o(ssr));

  fss_master_model fss_master_model_i (
    .ref_clk_i(ref_clk), .srst_i(srst), .online_i(online), .fault_i(fault),
    .other_mode_i(other_mode), .clash_i(clash), .units_i(units), .link_up_o(link_up),
    .comm_err_o(comm_err), .mode_mismatch_o(mm), .dup_station_o(dup), .sensor_cnt_o(scnt));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  // power cycle with the given switches; returns at the latching edge
  task automatic power_up(input logic [11:0] s);
    sw <= s;
    srst <= 1'b1;
    step(3);
    srst <= 1'b0;
    step(1);
  endtask

  // one apb transfer, held until pready is seen with the access phase
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    step(1);
    penable <= 1'b1;
    // no fixed wait count; only the watchdog ends a hung access
    do begin
      step(1);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    step(1);
  endtask

  // counts lit cycles of the error lamp over four flash half periods
  task automatic lit_count();
    n = 0;
    repeat (16) begin
      step(1);
      n += (err === 1'b1);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, over twenty times longer than the whole sequence
  initial begin
    step(5000);
    errors++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, srst, online, fault} = '0;
    {other_mode, clash, errors, n_compared} = '0;
    units = 5'd3;
    sw = 12'h122;
    foreach (ROWS[i]) begin
      power_up(ROWS[i][23:12]);
      step(1);
      check("setting", 32'(setting), 32'(ROWS[i][11:0]));
    end
    $display("test decode done");
    power_up(12'h122);
    // look in the middle of init, with sensors present and no stored count yet
    step(4);
    check("ss init", {ssg, ssr}, 2'b00);
    step(11);
    check("ss match", {ssg, ssr}, 2'b10);
    check("run down", run, 1'b0);
    check("err idle", err, 1'b0);
    online <= 1'b1;
    step(3);
    check("run up", run, 1'b1);
    units <= 5'd2;
    step(3);
    check("ss diff", {ssg, ssr}, 2'b01);
    units <= 5'd0;
    step(3);
    check("ss none", {ssg, ssr}, 2'b00);
    units <= 5'd3;
    $display("test lamps done");
    // move a switch while talking; only the event flag and flashing follow
    sw <= 12'h132;
    step(2);
    lit_count();
    check("flash", n > 0 && n < 16, 1'b1);
    check("latched", 32'(setting), {20'h0, 7'd12, 3'd2, 2'b01});
    apb(1'b0, OFS_EVENT, 32'h0);
    check("event", rd[0], 1'b1);
    sw <= 12'h122;
    apb(1'b1, OFS_EVENT, 32'h1);
    step(3);
    check("err cleared", err, 1'b0);
    apb(1'b0, OFS_SETTING, 32'h0);
    check("setting reg", rd, 32'h0000_220c);
    apb(1'b0, 12'hffc, 32'h0);
    check("unmapped", er, 1'b1);
    $display("test change done");
    fault <= 1'b1;
    step(3);
    lit_count();
    check("comm err", n, 16);
    fault <= 1'b0;
    step(3);
    check("comm ok", err, 1'b0);
    other_mode <= 1'b1;
    step(3);
    check("mode", err, 1'b1);
    other_mode <= 1'b0;
    clash <= 1'b1;
    step(1);
    clash <= 1'b0;
    step(10);
    check("halt", {halt, run, err}, 3'b101);
    $display("test faults done");
    power_up(12'h640);
    check("run reset", run, 1'b0);
    step(15);
    check("range", err, 1'b1);
    $display("test range done");
    end_sim();
  end
endmodule
